// [design/ifc_regs.sv]
// interrupt edge, external control and peripheral flag registers
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps

// Notes on behaviour
// - pull-up disable set turns all port pull-ups off; else each follows its latch
// - per-input edge select for ext 0,1,2: one rising, zero falling
// - edge register holds timer-0 and port-change priority bits, one is high
// - unimplemented bits ignore writes and read as zero
// - flags set on their event regardless of enables, so software may poll
// - ext2 and ext1 priority bits sit in bits 7 and 6, one is high
// - ext2 and ext1 enable bits, one allows, zero blocks
// - ext flags set on selected edge, cleared only by software write
// - parallel slave flag set on external read or write, sticky until cleared
// - conversion done flag set at end of conversion, sticky
// - receive flag read-only, one while receive buffer holds data
// - transmit flag read-only, one while transmit buffer empty
// - sync serial flag set when transfer completes, sticky
// - capture/compare one flag set on capture or match, unused in pwm
// - timer-2 match and timer-1 overflow flags, software clears
// - nonvolatile write flag set when write finishes
// - bus collision, low voltage and timer-3 flags, software clears
// - capture/compare two flag set on capture or match, unused in pwm
// - without priority, peripherals need the peripheral enable to interrupt
// - priority bits act only with priority enabled; else all go high
// - a flag requests only with its own and global enable set
module ifc_regs (
   input  wire logic             clk_i,          // system clock, 200 MHz
   input  wire logic             rst_i,          // synchronous reset, active high
   input  wire logic             ce_i,           // clock enable, low freezes state
   input  wire logic [3:0]       addr_i,         // register address
   input  wire logic [7:0]       wdata_i,        // write data
   input  wire logic             wr_i,           // write strobe
   input  wire logic             rd_i,           // read strobe
   output logic      [7:0]       rdata_o,        // read data, cycle after rd_i
   input  wire logic             ext1_i,         // external interrupt pin 1
   input  wire logic             ext2_i,         // external interrupt pin 2
   input  wire logic [7:0]       port_latch_i,   // port output latch values
   input  wire ifc_pkg::ifc_evt_t evt_i,         // peripheral events and levels
   input  wire ifc_pkg::ifc_en_t  en_i,          // outside enables and priorities
   output logic      [7:0]       pullup_en_o,    // per-pin pull-up on
   output logic      [2:0]       ext_edge_sel_o, // edge selects, ext0..ext2
   output logic                  tmr0_prio_o,    // timer-0 overflow priority
   output logic                  port_prio_o,    // port change priority
   output logic                  high_req_o,     // high-priority vector request
   output logic                  low_req_o       // low-priority vector request
);

   logic [7:0] edge_ctl;
   logic [7:0] ext_ctl;
   logic [7:0] flags1;
   logic [4:0] flags2;
   logic [1:0] ext_meta;
   logic [1:0] ext_sync;
   logic [1:0] ext_prev;
   logic [1:0] ext_edge;
   logic [1:0] ext_sel;
   logic [2:0] sync_fill;
   logic       wr_edge;
   logic       wr_ext;
   logic       wr_f1;
   logic       wr_f2;
   logic [7:0] set1;
   logic [4:0] set2;
   logic       pullup_dis;
   logic [7:0] next_rdata;
   logic       next_high;
   logic       next_low;
   logic [7:0] src1_act;
   logic [4:0] src2_act;
   logic [1:0] ext_act;
   logic [7:0] src1_hi;
   logic [4:0] src2_hi;
   logic [1:0] ext_hi;

   // write decode
   assign wr_edge = wr_i && (addr_i == ifc_pkg::OFS_EDGE_CTL);
   assign wr_ext  = wr_i && (addr_i == ifc_pkg::OFS_EXT_CTL);
   assign wr_f1   = wr_i && (addr_i == ifc_pkg::OFS_FLAGS1);
   assign wr_f2   = wr_i && (addr_i == ifc_pkg::OFS_FLAGS2);
   assign pullup_dis = edge_ctl[ifc_pkg::EC_PULLUP_DIS];

   // control register, only implemented bits take writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_ctl <= ifc_pkg::RST_EDGE_CTL;
      end else if (ce_i && wr_edge) begin
         edge_ctl <= wdata_i & ifc_pkg::MASK_EDGE_CTL;
      end
   end

   // two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta <= 2'h0;
         ext_sync <= 2'h0;
         ext_prev <= 2'h0;
      end else if (ce_i) begin
         ext_meta <= {ext2_i, ext1_i};
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end

   // fill marker for the pipeline above; a pin idling high after reset
   // would otherwise look like a rising edge against the cleared flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_fill <= 3'h0;
      end else if (ce_i) begin
         sync_fill <= {sync_fill[1:0], 1'b1};
      end
   end

   // selected edge per input gives one single-cycle set
   assign ext_sel = {edge_ctl[ifc_pkg::EC_EDGE2], edge_ctl[ifc_pkg::EC_EDGE1]};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         assign ext_edge[gi] = sync_fill[2] &&
                               (ext_sel[gi] ? (ext_sync[gi] && !ext_prev[gi])
                                            : (!ext_sync[gi] && ext_prev[gi]));
      end
   endgenerate

   // external control: priorities, enables and sticky flags
   // a write replaces the flags outright, so a coincident edge is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_ctl <= ifc_pkg::RST_EXT_CTL;
      end else if (ce_i) begin
         if (wr_ext) begin
            ext_ctl <= wdata_i & ifc_pkg::MASK_EXT_CTL;
         end else begin
            ext_ctl[1:0] <= ext_ctl[1:0] | ext_edge;
         end
      end
   end

   // hardware set vectors, aligned with the flag bit positions
   assign set1 = {evt_i.psp_done,
                  evt_i.adc_done,
                  2'h0,
                  evt_i.ssp_done,
                  evt_i.ccp1_event && !evt_i.ccp1_pwm,
                  evt_i.tmr2_match,
                  evt_i.tmr1_ovf};
   assign set2 = {evt_i.nvw_done,
                  evt_i.bus_coll,
                  evt_i.low_volt,
                  evt_i.tmr3_ovf,
                  evt_i.ccp2_event && !evt_i.ccp2_pwm};

   // first flag register; rx and tx mirror the serial buffer levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags1 <= ifc_pkg::RST_FLAGS1;
      end else if (ce_i) begin
         if (wr_f1) begin
            flags1 <= wdata_i & ifc_pkg::MASK_FLAGS1_W;
         end else begin
            flags1 <= (flags1 | set1) & ifc_pkg::MASK_FLAGS1_W;
         end
         flags1[ifc_pkg::F1_RX] <= evt_i.rx_full;
         flags1[ifc_pkg::F1_TX] <= evt_i.tx_empty;
      end
   end

   // second flag register, five implemented bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags2 <= ifc_pkg::RST_FLAGS2;
      end else if (ce_i) begin
         if (wr_f2) begin
            flags2 <= wdata_i[4:0];
         end else begin
            flags2 <= flags2 | set2;
         end
      end
   end

   // read mux; unmapped addresses and unimplemented bits give zero
   always_comb begin
      case (addr_i)
         ifc_pkg::OFS_EDGE_CTL: next_rdata = edge_ctl;
         ifc_pkg::OFS_EXT_CTL:  next_rdata = ext_ctl;
         ifc_pkg::OFS_FLAGS1:   next_rdata = flags1;
         ifc_pkg::OFS_FLAGS2:   next_rdata = {3'h0, flags2};
         default:               next_rdata = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
      end
   end

   // pull-ups and control bits out, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pullup_en_o    <= 8'h00;
         ext_edge_sel_o <= 3'h7;
         tmr0_prio_o    <= 1'b1;
         port_prio_o    <= 1'b1;
      end else if (ce_i) begin
         pullup_en_o    <= pullup_dis ? 8'h00 : port_latch_i;
         ext_edge_sel_o <= edge_ctl[ifc_pkg::EC_EDGE0:ifc_pkg::EC_EDGE2];
         tmr0_prio_o    <= edge_ctl[ifc_pkg::EC_TMR0_PRIO];
         port_prio_o    <= edge_ctl[ifc_pkg::EC_PORT_PRIO];
      end
   end

   // per-source active and high-priority terms
   // the software duty of keeping the slave port flag clear is trusted here
   assign src1_act = flags1 & en_i.pie1;
   assign src2_act = flags2 & en_i.pie2;
   assign ext_act  = ext_ctl[1:0] & {ext_ctl[ifc_pkg::XC_EXT2_EN], ext_ctl[ifc_pkg::XC_EXT1_EN]};
   assign src1_hi  = src1_act & en_i.ipr1;
   assign src2_hi  = src2_act & en_i.ipr2;
   assign ext_hi   = ext_act & {ext_ctl[ifc_pkg::XC_EXT2_PRIO], ext_ctl[ifc_pkg::XC_EXT1_PRIO]};

   // request resolution; compatibility mode sends all to the high vector
   always_comb begin
      next_high = 1'b0;
      next_low  = 1'b0;
      if (!en_i.priority_enable) begin
         next_high = en_i.global_irq_enable &&
                     ((|ext_act) ||
                      (en_i.peripheral_irq_enable && ((|src1_act) || (|src2_act))));
      end else begin
         next_high = en_i.global_irq_enable &&
                     ((|ext_hi) || (|src1_hi) || (|src2_hi));
         next_low  = en_i.global_irq_enable && en_i.peripheral_irq_enable &&
                     ((|(ext_act & ~ext_hi)) || (|(src1_act & ~src1_hi)) ||
                      (|(src2_act & ~src2_hi)));
      end
   end

   // registered requests toward the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_req_o <= 1'b0;
         low_req_o  <= 1'b0;
      end else if (ce_i) begin
         high_req_o <= next_high;
         low_req_o  <= next_low;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pullup_follow: assert property (ce_i |=> pullup_en_o ==
      ($past(pullup_dis) ? 8'h00 : $past(port_latch_i)))
      else $error("pull-up outputs disagree with disable bit and latch");

   a_rsvd_zero: assert property (((edge_ctl & ~ifc_pkg::MASK_EDGE_CTL) == 8'h00) &&
      ((ext_ctl & ~ifc_pkg::MASK_EXT_CTL) == 8'h00))
      else $error("unimplemented control bit became set");

   a_ext1_edge_set: assert property (ce_i && ext_edge[0] && !wr_ext |=> ext_ctl[0])
      else $error("ext1 edge did not set its flag");

   a_ext_write_wins: assert property (ce_i && wr_ext |=>
      ext_ctl == ($past(wdata_i) & ifc_pkg::MASK_EXT_CTL))
      else $error("ext register write not taken over hardware set");

   a_one_edge_pulse: assert property (ext_edge[0] |=> !ext_edge[0] || !ce_i)
      else $error("ext1 edge produced more than one set event");

   a_flag_sticky: assert property (ce_i && !wr_f1 && flags1[7] |=> flags1[7])
      else $error("slave port flag cleared without a write");

   a_rx_mirror: assert property (ce_i |=> flags1[5] == $past(evt_i.rx_full))
      else $error("receive flag does not follow buffer level");

   a_pwm_no_set: assert property (ce_i && !wr_f1 && !flags1[2] &&
      evt_i.ccp1_pwm |=> !flags1[2])
      else $error("capture compare flag set in pwm mode");

   a_compat_no_low: assert property (ce_i && !en_i.priority_enable |=> !low_req_o)
      else $error("low request raised in compatibility mode");

   a_global_gate: assert property (ce_i && !en_i.global_irq_enable |=>
      !high_req_o && !low_req_o)
      else $error("request raised with global enable clear");

   a_read_flags2: assert property (rd_i && ce_i && addr_i == ifc_pkg::OFS_FLAGS2 |=>
      rdata_o == {3'h0, $past(flags2)})
      else $error("second flag register read wrong");

   a_tx_mirror: assert property (ce_i |=> flags1[4] == $past(evt_i.tx_empty))
      else $error("transmit flag does not follow buffer level");

   a_ext2_edge_set: assert property (ce_i && ext_edge[1] && !wr_ext |=> ext_ctl[1])
      else $error("ext2 edge did not set its flag");

   a_conv_set: assert property (ce_i && !wr_f1 && evt_i.adc_done |=> flags1[6])
      else $error("conversion done did not set its flag");

   a_coll_set: assert property (ce_i && !wr_f2 && evt_i.bus_coll |=> flags2[3])
      else $error("bus collision did not set its flag");

   a_flags1_wins: assert property (ce_i && wr_f1 |=> flags1[7] == $past(wdata_i[7]))
      else $error("flag write not taken over hardware set");

   a_compat_pe_gate: assert property (ce_i && !en_i.priority_enable &&
      !en_i.peripheral_irq_enable && !(|ext_act) |=> !high_req_o)
      else $error("peripheral request passed without peripheral enable");

   a_edge_sel_out: assert property (ce_i |=>
      ext_edge_sel_o == $past(edge_ctl[ifc_pkg::EC_EDGE0:ifc_pkg::EC_EDGE2]))
      else $error("edge select outputs disagree with control register");

   c_ext2_rise: cover property (ext_edge[1] ##1 ext_ctl[1]);
   c_high_req: cover property (en_i.priority_enable ##1 high_req_o);
   c_low_req: cover property (low_req_o);
   c_write_clash: cover property (wr_f2 && (|set2));

endmodule : ifc_regs

// [design/ifc_pkg.sv]
// shared constants and carriers for the interrupt flag and control registers
package ifc_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_EDGE_CTL = 4'h0;  // edge_and_pullup_control
   localparam logic [3:0] OFS_EXT_CTL  = 4'h1;  // external_irq_control
   localparam logic [3:0] OFS_FLAGS1   = 4'h2;  // peripheral_flags_one
   localparam logic [3:0] OFS_FLAGS2   = 4'h3;  // peripheral_flags_two

   // reset values
   localparam logic [7:0] RST_EDGE_CTL = 8'hf5;
   localparam logic [7:0] RST_EXT_CTL  = 8'hc0;
   localparam logic [7:0] RST_FLAGS1   = 8'h00;
   localparam logic [4:0] RST_FLAGS2   = 5'h00;

   // implemented-bit masks
   localparam logic [7:0] MASK_EDGE_CTL = 8'hf5;
   localparam logic [7:0] MASK_EXT_CTL  = 8'hdb;
   localparam logic [7:0] MASK_FLAGS1_W = 8'hcf;  // bits 5 and 4 are read-only
   localparam logic [7:0] MASK_FLAGS2   = 8'h1f;

   // edge_and_pullup_control fields
   localparam int EC_PULLUP_DIS = 7;
   localparam int EC_EDGE0      = 6;
   localparam int EC_EDGE1      = 5;
   localparam int EC_EDGE2      = 4;
   localparam int EC_TMR0_PRIO  = 2;
   localparam int EC_PORT_PRIO  = 0;

   // external_irq_control fields
   localparam int XC_EXT2_PRIO = 7;
   localparam int XC_EXT1_PRIO = 6;
   localparam int XC_EXT2_EN   = 4;
   localparam int XC_EXT1_EN   = 3;
   localparam int XC_EXT2_FLAG = 1;
   localparam int XC_EXT1_FLAG = 0;

   // peripheral_flags_one read-only positions
   localparam int F1_RX = 5;
   localparam int F1_TX = 4;

   // event pulses and levels from the peripherals, same clock domain
   typedef struct packed {
      logic psp_done;    // parallel slave port read or write completed
      logic adc_done;    // conversion finished
      logic rx_full;     // level: receive buffer holds data
      logic tx_empty;    // level: transmit buffer empty
      logic ssp_done;    // sync serial transfer complete
      logic ccp1_event;  // capture or compare match, unit one
      logic ccp1_pwm;    // level: unit one in pwm mode
      logic tmr2_match;  // timer 2 equals period
      logic tmr1_ovf;    // timer 1 overflow
      logic nvw_done;    // nonvolatile write finished
      logic bus_coll;    // bus collision
      logic low_volt;    // supply below trip point
      logic tmr3_ovf;    // timer 3 overflow
      logic ccp2_event;  // capture or compare match, unit two
      logic ccp2_pwm;    // level: unit two in pwm mode
   } ifc_evt_t;

   // enable and priority bits kept outside this block
   typedef struct packed {
      logic       priority_enable;        // priority levels on
      logic       global_irq_enable;      // global enable, high level when priority on
      logic       peripheral_irq_enable;  // peripheral enable, low level when priority on
      logic [7:0] pie1;                   // peripheral enables, first group
      logic [4:0] pie2;                   // peripheral enables, second group
      logic [7:0] ipr1;                   // peripheral priorities, first group
      logic [4:0] ipr2;                   // peripheral priorities, second group
   } ifc_en_t;

endpackage : ifc_pkg

// [dv/ifc_evt_model.sv]
// peripheral event source model facing the flag registers
`timescale 1ns/10ps
module ifc_evt_model (
   input  wire logic        go_i,   // fire one pulse this cycle
   input  wire logic [3:0]  src_i,  // which source fires
   input  wire logic        rx_i,   // receive buffer holds data
   input  wire logic        tx_i,   // transmit buffer empty
   input  wire logic        pwm1_i, // unit one in pwm mode
   input  wire logic        pwm2_i, // unit two in pwm mode
   output ifc_pkg::ifc_evt_t evt_o  // events toward the registers
);
   // a pulse lasts only the go cycle, so each request is one flag set
   always_comb begin
      evt_o          = '0;
      evt_o.rx_full  = rx_i;
      evt_o.tx_empty = tx_i;
      evt_o.ccp1_pwm = pwm1_i;
      evt_o.ccp2_pwm = pwm2_i;
      if (go_i) begin
         case (src_i)
            4'h0: evt_o.psp_done   = 1'b1;
            4'h1: evt_o.adc_done   = 1'b1;
            4'h2: evt_o.ssp_done   = 1'b1;
            4'h3: evt_o.ccp1_event = 1'b1;
            4'h4: evt_o.tmr2_match = 1'b1;
            4'h5: evt_o.tmr1_ovf   = 1'b1;
            4'h6: evt_o.nvw_done   = 1'b1;
            4'h7: evt_o.bus_coll   = 1'b1;
            4'h8: evt_o.low_volt   = 1'b1;
            4'h9: evt_o.tmr3_ovf   = 1'b1;
            default: evt_o.ccp2_event = 1'b1;
         endcase
      end
   end
endmodule : ifc_evt_model

// [dv/ifc_regs_tb.sv]
// self-checking bench for the interrupt flag and control registers
`timescale 1ns/10ps
module ifc_regs_tb;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [3:0]        addr_i = 4'h0;
   logic [7:0]        wdata_i = 8'h00;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic              ext1_i = 1'b0;
   logic              ext2_i = 1'b1;
   logic              ce = 1'b1;
   logic              go = 1'b0;
   logic [3:0]        src = 4'h0;
   logic              rx = 1'b0;
   logic              tx = 1'b0;
   logic              pwm1 = 1'b0;
   logic              pwm2 = 1'b0;
   ifc_pkg::ifc_en_t  en = '0;
   ifc_pkg::ifc_evt_t evt;
   logic [7:0]        rdata_o;
   logic [7:0]        pullup_en_o;
   logic [2:0]        ext_edge_sel_o;
   logic              tmr0_prio_o;
   logic              port_prio_o;
   logic              high_req_o;
   logic              low_req_o;
   int                err_total = 0;
   int                comparisons = 0;
   int                cyc = 0;

   always #2.5 clk_i = ~clk_i;

   ifc_evt_model u_src (.go_i(go), .src_i(src), .rx_i(rx), .tx_i(tx), .pwm1_i(pwm1),
      .pwm2_i(pwm2), .evt_o(evt));

   ifc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext1_i(ext1_i), .ext2_i(ext2_i),
      .port_latch_i(8'h5a), .evt_i(evt), .en_i(en), .pullup_en_o(pullup_en_o),
      .ext_edge_sel_o(ext_edge_sel_o), .tmr0_prio_o(tmr0_prio_o), .port_prio_o(port_prio_o),
      .high_req_o(high_req_o), .low_req_o(low_req_o));

   task automatic close_out;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe; looked at mid-cycle
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o, e);
      @(posedge clk_i);
   endtask : rdc

   task automatic pulse(input logic [3:0] k);
      @(posedge clk_i);
      go <= 1'b1;
      src <= k;
      @(posedge clk_i);
      go <= 1'b0;
   endtask : pulse

   task automatic t_access;
      rdc(4'h0, 8'hf5);
      rdc(4'h1, 8'hc0);
      rdc(4'h2, 8'h00);
      rdc(4'h3, 8'h00);
      chk({3'h0, ext_edge_sel_o, tmr0_prio_o, port_prio_o}, 8'h1f);
      chk(pullup_en_o, 8'h00);
      for (int i = 0; i < 4; i++) wr(i[3:0], 8'hff);
      wr(4'h9, 8'hff);
      rdc(4'h9, 8'h00);
      rdc(4'h0, 8'hf5);
      rdc(4'h1, 8'hdb);
      rdc(4'h2, 8'hcf);
      rdc(4'h3, 8'h1f);
      wr(4'h0, 8'h20);
      @(posedge clk_i);
      @(negedge clk_i);
      chk(pullup_en_o, 8'h5a);
      chk({3'h0, ext_edge_sel_o, tmr0_prio_o, port_prio_o}, 8'h08);
      for (int i = 1; i < 4; i++) wr(i[3:0], 8'h00);
   endtask : t_access

   // every peripheral source sets its own bit with all enables off
   task automatic t_events;
      logic [3:0] a;
      logic [7:0] m;
      for (int k = 0; k < 11; k++) begin
         a = (k < 6) ? 4'h2 : 4'h3;
         m = (k < 6) ? (8'h01 << ((k < 2) ? 7 - k : 5 - k)) : (8'h01 << (10 - k));
         pulse(k[3:0]);
         rdc(a, m);
         wr(a, 8'h00);
         rdc(a, 8'h00);
      end
   endtask : t_events

   task automatic t_levels;
      @(posedge clk_i);
      rx <= 1'b1;
      rdc(4'h2, 8'h20);
      wr(4'h2, 8'h00);
      rdc(4'h2, 8'h20);
      rx <= 1'b0;
      tx <= 1'b1;
      rdc(4'h2, 8'h10);
      tx <= 1'b0;
      pwm1 <= 1'b1;
      pwm2 <= 1'b1;
      pulse(4'h3);
      pulse(4'ha);
      rdc(4'h2, 8'h00);
      rdc(4'h3, 8'h00);
      pwm1 <= 1'b0;
      pwm2 <= 1'b0;
   endtask : t_levels

   // with the clock enable low neither an event nor a write may land
   task automatic t_freeze;
      @(posedge clk_i);
      ce <= 1'b0;
      pulse(4'h1);
      wr(4'h3, 8'h1f);
      ce <= 1'b1;
      rdc(4'h2, 8'h00);
      rdc(4'h3, 8'h00);
   endtask : t_freeze

   // ext1 rising and ext2 falling selected; the other polarity must not set
   task automatic t_ext;
      repeat (4) @(posedge clk_i);
      wr(4'h1, 8'h00);
      ext1_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rdc(4'h1, 8'h01);
      ext2_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rdc(4'h1, 8'h03);
      wr(4'h1, 8'h00);
      ext1_i <= 1'b0;
      ext2_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rdc(4'h1, 8'h00);
   endtask : t_ext

   // clear write lands on the same edge as a conversion done pulse
   task automatic t_wins;
      @(posedge clk_i);
      go <= 1'b1;
      src <= 4'h1;
      addr_i <= 4'h2;
      wdata_i <= 8'h00;
      wr_i <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      wr_i <= 1'b0;
      rdc(4'h2, 8'h00);
      pulse(4'h1);
      rdc(4'h2, 8'h40);
   endtask : t_wins

   task automatic req(input logic p, g, pe, input logic [7:0] ie, ip, input logic [1:0] e);
      @(posedge clk_i);
      en <= '{p, g, pe, ie, 5'h00, ip, 5'h00};
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk({6'h0, high_req_o, low_req_o}, {6'h0, e});
      @(posedge clk_i);
   endtask : req

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_access();
      t_events();
      t_levels();
      t_freeze();
      t_ext();
      t_wins();
      req(1'b0, 1'b1, 1'b0, 8'h40, 8'h00, 2'b00);
      req(1'b0, 1'b1, 1'b1, 8'h40, 8'h00, 2'b10);
      req(1'b1, 1'b1, 1'b1, 8'h40, 8'h00, 2'b01);
      req(1'b1, 1'b1, 1'b1, 8'h40, 8'h40, 2'b10);
      req(1'b1, 1'b0, 1'b1, 8'h40, 8'h40, 2'b00);
      req(1'b0, 1'b1, 1'b1, 8'h00, 8'h40, 2'b00);
      close_out();
   end
endmodule : ifc_regs_tb
